// ---- verilog/crro_pkg.sv ----
// constants, types and register map for the call/return/reset executor
package crro_pkg;

  // ----------------------------------------------------------------
  // widths and stack size
  // ----------------------------------------------------------------
  localparam int CRRO_PC_W = 21;
  localparam int CRRO_STK_DEPTH = 31;
  localparam int CRRO_SP_W = 5;
  localparam logic [20:0] CRRO_PC_STEP = 21'h000002;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [4:0] CRRO_OP_CALL_HI = 5'h1B;   // 1101 1nnn ...
  localparam logic [15:0] CRRO_OP_SRST = 16'h00FF;
  localparam logic [14:0] CRRO_OP_IRET_HI = 15'h0008; // 0000 0000 0001 000s
  localparam logic [7:0] CRRO_OP_LRET_HI = 8'h0C;     // 0000 1100 kkkk kkkk

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CRRO_OFS_OPCODE = 8'h00;
  localparam logic [7:0] CRRO_OFS_STAT = 8'h04;
  localparam logic [7:0] CRRO_OFS_PC = 8'h08;
  localparam logic [7:0] CRRO_OFS_STKTOP = 8'h0C;
  localparam logic [7:0] CRRO_OFS_WORK = 8'h10;
  localparam logic [7:0] CRRO_OFS_FLAGS = 8'h14;
  localparam logic [7:0] CRRO_OFS_BANK = 8'h18;
  localparam logic [7:0] CRRO_OFS_SHADOW = 8'h1C;
  localparam logic [7:0] CRRO_OFS_IRQCFG = 8'h20;
  localparam logic [7:0] CRRO_OFS_LATCH = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CRRO_STAT_BUSY = 0;
  localparam int CRRO_STAT_PEND = 1;
  localparam int CRRO_STAT_BAD = 2;
  localparam int CRRO_STAT_SP_LSB = 8;
  localparam int CRRO_SHD_FLAGS_LSB = 8;
  localparam int CRRO_SHD_BANK_LSB = 16;
  localparam int CRRO_IRQ_HIGH = 0;
  localparam int CRRO_IRQ_LOW = 1;
  localparam int CRRO_IRQ_PRIO = 2;
  localparam int CRRO_LAT_UP_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [20:0] CRRO_PC_RST = 21'h000000;
  localparam logic [7:0] CRRO_BYTE_RST = 8'h00;
  localparam logic [4:0] CRRO_UP_RST = 5'h00;
  localparam logic [15:0] CRRO_OP_RST = 16'h0000;

  // ----------------------------------------------------------------
  // quarter phases (gray around the loop) and instruction cycles (gray except CYC2 back to IDLE)
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CRRO_Q1 = 2'b00,
    CRRO_Q2 = 2'b01,
    CRRO_Q3 = 2'b11,
    CRRO_Q4 = 2'b10
  } crro_q_t;

  typedef enum logic [1:0]
  {
    CRRO_IDLE = 2'b00,
    CRRO_CYC1 = 2'b01,
    CRRO_CYC2 = 2'b11
  } crro_cyc_t;

  // ----------------------------------------------------------------
  // return stack command carrier and stack state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic push;
    logic pop;
    logic clr;
    logic [20:0] data;
  } crro_stk_cmd_t;

  typedef struct packed {
    logic [CRRO_STK_DEPTH-1:0][CRRO_PC_W-1:0] mem;
    logic [CRRO_SP_W-1:0] sp;
  } crro_stk_st_t;

  // ----------------------------------------------------------------
  // executor state
  // ----------------------------------------------------------------
  typedef struct packed {
    crro_q_t q;
    crro_cyc_t cyc;
    logic [15:0] op;
    logic pend;
    logic bad;
    logic [20:0] pc;
    logic [7:0] work;
    logic [7:0] flags;
    logic [7:0] bank;
    logic [7:0] work_sh;
    logic [7:0] flags_sh;
    logic [7:0] bank_sh;
    logic irq_high;
    logic irq_low;
    logic prio;
    logic [4:0] pc_up;
    logic [7:0] pc_hi;
    logic wr_pend;
    logic rd_pend;
    logic hit;
    logic [7:0] addr;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic srst;
  } crro_st_t;

endpackage

// ---- verilog/crro_stack.sv ----
// return stack holding program counter values
`timescale 1ns/10ps
module crro_stack
  import crro_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // commands
  input crro_stk_cmd_t cmd,
  // state seen by the executor
  output logic [20:0] stack_top,
  output logic [4:0] depth
);

  crro_stk_st_t s_q;
  crro_stk_st_t s_d;

  // ----------------------------------------------------------------
  // next state: push to free slot, pop drops top, clear empties
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (cmd.push && (s_q.sp < CRRO_SP_W'(CRRO_STK_DEPTH)))
    begin
      s_d.mem[s_q.sp] = cmd.data;
      s_d.sp = s_q.sp + 5'h01;
    end
    else if (cmd.pop && (s_q.sp != 5'h00))
    begin
      s_d.sp = s_q.sp - 5'h01;
    end
    if (cmd.clr || !nrst)
    begin
      s_d.sp = 5'h00;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  // top reads zero when empty
  assign stack_top = (s_q.sp == 5'h00) ? CRRO_PC_RST : s_q.mem[s_q.sp - 5'h01];
  assign depth = s_q.sp;

endmodule

// ---- verilog/crro_core.sv ----
// executor for relative call, software reset and the two returns
// Operation
// - A relative call jumps to its own address plus two plus twice its signed 11-bit offset.
// - A relative call pushes its own address plus two onto the return stack.
// - A call decodes in Q1, pushes in Q2, writes the counter in Q4, then idles one cycle.
// - Opcode 00FF resets every architectural register and flag to its reset value.
// - The software reset lasts one cycle and starts the reset in its second quarter.
// - Interrupt return pops the counter and sets the high or low interrupt enable.
// - Interrupt return with its low bit set restores work, flags and bank from shadows.
// - Literal return loads its literal into work, pops the counter, keeps the latches.
`timescale 1ns/10ps
module crro_core
  import crro_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // software reset pulse
  output logic soft_reset_pulse
);

  crro_st_t s_q;
  crro_st_t s_d;
  crro_stk_cmd_t stk_cmd;
  logic [20:0] stack_top;
  logic [4:0] depth;
  logic is_call;
  logic is_srst;
  logic is_iret;
  logic is_lret;
  logic busy;
  logic acc;
  logic [20:0] ret_addr;
  logic [20:0] call_tgt;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // opcode decode and derived addresses
  // ----------------------------------------------------------------
  assign is_call = (s_q.op[15:11] == CRRO_OP_CALL_HI);
  assign is_srst = (s_q.op == CRRO_OP_SRST);
  assign is_iret = (s_q.op[15:1] == CRRO_OP_IRET_HI);
  assign is_lret = (s_q.op[15:8] == CRRO_OP_LRET_HI);
  assign busy = (s_q.cyc != CRRO_IDLE);
  assign ret_addr = s_q.pc + CRRO_PC_STEP;
  assign call_tgt = ret_addr + {{9{s_q.op[10]}}, s_q.op[10:0], 1'b0};
  assign acc = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  always_comb
  begin
    stk_cmd.push = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q2) && is_call;
    stk_cmd.pop = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q4)
      && (is_iret || is_lret);
    stk_cmd.clr = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q2) && is_srst;
    stk_cmd.data = ret_addr;
  end

  crro_stack u_stack (
    .clk(clk),
    .nrst(nrst),
    .cmd(stk_cmd),
    .stack_top(stack_top),
    .depth(depth)
  );

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (s_q.addr)
      CRRO_OFS_OPCODE: rd_mux[15:0] = s_q.op;
      CRRO_OFS_STAT:
      begin
        rd_mux[CRRO_STAT_BUSY] = busy;
        rd_mux[CRRO_STAT_PEND] = s_q.pend;
        rd_mux[CRRO_STAT_BAD] = s_q.bad;
        rd_mux[CRRO_STAT_SP_LSB +: 5] = depth;
      end
      CRRO_OFS_PC: rd_mux[20:0] = s_q.pc;
      CRRO_OFS_STKTOP: rd_mux[20:0] = stack_top;
      CRRO_OFS_WORK: rd_mux[7:0] = s_q.work;
      CRRO_OFS_FLAGS: rd_mux[7:0] = s_q.flags;
      CRRO_OFS_BANK: rd_mux[7:0] = s_q.bank;
      CRRO_OFS_SHADOW:
        rd_mux[23:0] = {s_q.bank_sh, s_q.flags_sh, s_q.work_sh};
      CRRO_OFS_IRQCFG: rd_mux[2:0] = {s_q.prio, s_q.irq_low, s_q.irq_high};
      CRRO_OFS_LATCH: rd_mux[12:0] = {s_q.pc_up, s_q.pc_hi};
      default: rd_mux = 32'h00000000;
    endcase
    if (!s_q.hit)
    begin
      rd_mux = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // architectural reset of every register and flag
  // ----------------------------------------------------------------
  function automatic crro_st_t arch_rst(input crro_st_t s);
    crro_st_t r;
    r = s;
    r.cyc = CRRO_IDLE;
    r.op = CRRO_OP_RST;
    r.pend = 1'b0;
    r.bad = 1'b0;
    r.pc = CRRO_PC_RST;
    r.work = CRRO_BYTE_RST;
    r.flags = CRRO_BYTE_RST;
    r.bank = CRRO_BYTE_RST;
    r.work_sh = CRRO_BYTE_RST;
    r.flags_sh = CRRO_BYTE_RST;
    r.bank_sh = CRRO_BYTE_RST;
    r.irq_high = 1'b0;
    r.irq_low = 1'b0;
    r.prio = 1'b0;
    r.pc_up = CRRO_UP_RST;
    r.pc_hi = CRRO_BYTE_RST;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state: quarter phase, bus slave, execution, reset
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.srst = 1'b0;
    // quarter phase sequencer
    case (s_q.q)
      CRRO_Q1: s_d.q = CRRO_Q2;
      CRRO_Q2: s_d.q = CRRO_Q3;
      CRRO_Q3: s_d.q = CRRO_Q4;
      CRRO_Q4: s_d.q = CRRO_Q1;
      default: s_d.q = CRRO_Q1;
    endcase
    // bus address phase; reads take one wait state
    s_d.wr_pend = acc && hwrite;
    s_d.rd_pend = acc && !hwrite;
    if (acc)
    begin
      s_d.addr = haddr[7:0];
      s_d.hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
      s_d.hready = hwrite;
    end
    if (s_q.rd_pend)
    begin
      s_d.hrdata = rd_mux;
      s_d.hready = 1'b1;
    end
    // bus data phase of a write; while an opcode is pending or in flight only the STAT bad clear is taken
    if (s_q.wr_pend && s_q.hit)
    begin
      if (s_q.addr == CRRO_OFS_STAT && hwdata[CRRO_STAT_BAD])
      begin
        s_d.bad = 1'b0;
      end
      if (!busy && !s_q.pend)
      begin
        case (s_q.addr)
          CRRO_OFS_OPCODE:
          begin
            s_d.op = hwdata[15:0];
            s_d.pend = 1'b1;
          end
          CRRO_OFS_PC: s_d.pc = hwdata[20:0];
          CRRO_OFS_WORK: s_d.work = hwdata[7:0];
          CRRO_OFS_FLAGS: s_d.flags = hwdata[7:0];
          CRRO_OFS_BANK: s_d.bank = hwdata[7:0];
          CRRO_OFS_SHADOW:
          begin
            s_d.work_sh = hwdata[7:0];
            s_d.flags_sh = hwdata[CRRO_SHD_FLAGS_LSB +: 8];
            s_d.bank_sh = hwdata[CRRO_SHD_BANK_LSB +: 8];
          end
          CRRO_OFS_IRQCFG:
          begin
            s_d.irq_high = hwdata[CRRO_IRQ_HIGH];
            s_d.irq_low = hwdata[CRRO_IRQ_LOW];
            s_d.prio = hwdata[CRRO_IRQ_PRIO];
          end
          CRRO_OFS_LATCH:
          begin
            s_d.pc_hi = hwdata[7:0];
            s_d.pc_up = hwdata[CRRO_LAT_UP_LSB +: 5];
          end
          default: s_d.pc = s_q.pc;
        endcase
      end
    end
    // instruction execution
    case (s_q.cyc)
      CRRO_IDLE:
      begin
        if (s_q.pend && s_q.q == CRRO_Q4)
        begin
          s_d.cyc = CRRO_CYC1;
          s_d.pend = 1'b0;
        end
      end
      CRRO_CYC1:
      begin
        case (s_q.q)
          CRRO_Q1:
          begin
            // unknown opcode: flag it and drop it (set beats clear)
            if (!(is_call || is_srst || is_iret || is_lret))
            begin
              s_d.bad = 1'b1;
              s_d.cyc = CRRO_IDLE;
            end
          end
          CRRO_Q2:
          begin
            if (is_srst)
            begin
              s_d = arch_rst(s_d);
              s_d.srst = 1'b1;
            end
          end
          CRRO_Q4:
          begin
            s_d.cyc = CRRO_CYC2;
            if (is_call)
            begin
              s_d.pc = call_tgt;
            end
            if (is_iret)
            begin
              s_d.pc = stack_top;
              if (!s_q.prio || !s_q.irq_high)
              begin
                s_d.irq_high = 1'b1;
              end
              else
              begin
                s_d.irq_low = 1'b1;
              end
              if (s_q.op[0])
              begin
                s_d.work = s_q.work_sh;
                s_d.flags = s_q.flags_sh;
                s_d.bank = s_q.bank_sh;
              end
            end
            if (is_lret)
            begin
              s_d.work = s_q.op[7:0];
              s_d.pc = stack_top;
            end
          end
          default: s_d.cyc = CRRO_CYC1;
        endcase
      end
      CRRO_CYC2:
      begin
        if (s_q.q == CRRO_Q4)
        begin
          s_d.cyc = CRRO_IDLE;
        end
      end
      default: s_d.cyc = CRRO_IDLE;
    endcase
    // power-on reset
    if (!nrst)
    begin
      s_d = arch_rst(s_q);
      s_d.q = CRRO_Q1;
      s_d.wr_pend = 1'b0;
      s_d.rd_pend = 1'b0;
      s_d.hit = 1'b0;
      s_d.addr = 8'h00;
      s_d.hready = 1'b1;
      s_d.hrdata = 32'h00000000;
      s_d.hresp = 1'b0;
      s_d.srst = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  // outputs straight from the state register
  assign hreadyout = s_q.hready;
  assign hrdata = s_q.hrdata;
  assign hresp = s_q.hresp;
  assign soft_reset_pulse = s_q.srst;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic c1q1;
  logic c1q2;
  logic c1q4;
  assign c1q1 = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q1);
  assign c1q2 = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q2);
  assign c1q4 = (s_q.cyc == CRRO_CYC1) && (s_q.q == CRRO_Q4);

  AST_CALL_TARGET: assert property (
    c1q4 && is_call |=> s_q.pc == $past(s_q.pc) + CRRO_PC_STEP
      + {{9{$past(s_q.op[10])}}, $past(s_q.op[10:0]), 1'b0})
    else $error("call target wrong");

  AST_CALL_PUSH: assert property (
    c1q2 && is_call && depth < 5'h1F |=> stack_top == $past(s_q.pc) + 21'h2
      && depth == $past(depth) + 5'h01)
    else $error("call did not push return address");

  AST_CALL_TIMING: assert property (
    c1q1 && is_call |-> ##1 $stable(s_q.pc) [*3] ##1
      (s_q.cyc == CRRO_CYC2) ##4 (s_q.cyc == CRRO_IDLE))
    else $error("call quarter timing wrong");

  AST_SRST_EFFECT: assert property (
    c1q2 && is_srst |=> s_q.pc == CRRO_PC_RST && s_q.work == CRRO_BYTE_RST
      && !s_q.irq_high && !s_q.prio && depth == 5'h00 && soft_reset_pulse)
    else $error("software reset missed a register");

  AST_SRST_CYCLE: assert property (
    c1q1 && is_srst |=> !soft_reset_pulse && c1q2 ##1
      soft_reset_pulse && s_q.cyc == CRRO_IDLE ##1 !soft_reset_pulse)
    else $error("software reset not one cycle");

  AST_IRET_POP: assert property (
    c1q4 && is_iret |=> s_q.pc == $past(stack_top)
      && (s_q.irq_high || s_q.irq_low))
    else $error("interrupt return pop or enable wrong");

  AST_IRET_FAST: assert property (
    c1q4 && is_iret |=> s_q.work == ($past(s_q.op[0]) ? $past(s_q.work_sh)
      : $past(s_q.work)) && s_q.bank == ($past(s_q.op[0])
      ? $past(s_q.bank_sh) : $past(s_q.bank)))
    else $error("shadow restore wrong");

  AST_LRET: assert property (
    c1q4 && is_lret |=> s_q.work == $past(s_q.op[7:0])
      && s_q.pc == $past(stack_top) && $stable(s_q.pc_hi)
      && $stable(s_q.pc_up))
    else $error("literal return wrong");

  AST_RET_IDLE: assert property (
    c1q4 && (is_iret || is_lret) |=> (s_q.cyc == CRRO_CYC2) ##1
      (s_q.cyc == CRRO_CYC2 && $stable(s_q.pc) && $stable(s_q.work)) [*3]
      ##1 (s_q.cyc == CRRO_IDLE))
    else $error("return second cycle not idle");

  COV_CALL: cover property (c1q4 && is_call);
  COV_IRET_FAST: cover property (c1q4 && is_iret && s_q.op[0]);
  COV_LRET: cover property (c1q4 && is_lret);
  COV_SRST: cover property (soft_reset_pulse);

endmodule

// ---- dv/tb_crro_core.sv ----
// self-checking bench for the call, return and reset executor
`timescale 1ns/10ps
module tb_crro_core
  import crro_pkg::*;
;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic soft_reset_pulse;
  int miscompares = 0;
  int checks_done = 0;
  int pulses = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // count software reset pulses as they stand
  always @(posedge clk)
    if (soft_reset_pulse === 1'b1)
      pulses <= pulses + 1;

  crro_core DUT (
    .clk(clk),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .soft_reset_pulse(soft_reset_pulse)
  );

  // ----------------------------------------------------------------
  // report and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("MISMATCH %s expected done seen stuck", what);
    give_verdict();
  endtask

  task automatic check32(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // wait for an edge with ready high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
        hang("bus ready");
      @(posedge clk);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {24'h000000, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {24'h000000, a};
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] v;
    bus_read(a, v);
    check32(name, exp, v);
    check32("hresp", 32'h00000000, {31'h00000000, hresp});
  endtask

  // launch an opcode, optionally poke flags while pending, then poll
  task automatic run_op(input logic [15:0] op, input bit poke);
    logic [31:0] s;
    int n;
    bus_write(CRRO_OFS_OPCODE, {16'h0000, op});
    if (poke)
      bus_write(CRRO_OFS_FLAGS, 32'h00000099);
    s = 32'h00000003;
    n = 0;
    while (s[1:0] !== 2'b00)
    begin
      n++;
      if (n > 40)
        hang("opcode busy");
      bus_read(CRRO_OFS_STAT, s);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_after_reset();
    rd_chk("pc", CRRO_OFS_PC, 32'h00000000);
    rd_chk("stat", CRRO_OFS_STAT, 32'h00000000);
    rd_chk("stack top", CRRO_OFS_STKTOP, 32'h00000000);
    bus_write(8'h40, 32'h12345678);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    $display("test after_reset done");
  endtask

  // extreme offsets, back to back calls
  task automatic t_call();
    bus_write(CRRO_OFS_PC, 32'h00000124);
    run_op(16'hDC00, 1'b0);
    rd_chk("pc", CRRO_OFS_PC, 32'h001FF926);
    rd_chk("stack top", CRRO_OFS_STKTOP, 32'h00000126);
    rd_chk("depth", CRRO_OFS_STAT, 32'h00000100);
    run_op(16'hDBFF, 1'b0);
    rd_chk("pc", CRRO_OFS_PC, 32'h00000126);
    rd_chk("stack top", CRRO_OFS_STKTOP, 32'h001FF928);
    rd_chk("depth", CRRO_OFS_STAT, 32'h00000200);
    $display("test call done");
  endtask

  // literal return with a refused write while pending
  task automatic t_lit_return();
    bus_write(CRRO_OFS_LATCH, 32'h00001FAB);
    run_op(16'h0CA5, 1'b1);
    rd_chk("work", CRRO_OFS_WORK, 32'h000000A5);
    rd_chk("pc", CRRO_OFS_PC, 32'h001FF928);
    rd_chk("latch", CRRO_OFS_LATCH, 32'h00001FAB);
    rd_chk("flags kept", CRRO_OFS_FLAGS, 32'h00000000);
    rd_chk("stack top", CRRO_OFS_STKTOP, 32'h00000126);
    rd_chk("depth", CRRO_OFS_STAT, 32'h00000100);
    $display("test lit_return done");
  endtask

  // interrupt return with shadow restore, priority mode off
  task automatic t_irq_return_fast();
    bus_write(CRRO_OFS_SHADOW, 32'h00332211);
    bus_write(CRRO_OFS_IRQCFG, 32'h00000000);
    run_op(16'h0011, 1'b0);
    rd_chk("pc", CRRO_OFS_PC, 32'h00000126);
    rd_chk("irq cfg", CRRO_OFS_IRQCFG, 32'h00000001);
    rd_chk("work", CRRO_OFS_WORK, 32'h00000011);
    rd_chk("flags", CRRO_OFS_FLAGS, 32'h00000022);
    rd_chk("bank", CRRO_OFS_BANK, 32'h00000033);
    rd_chk("depth", CRRO_OFS_STAT, 32'h00000000);
    $display("test irq_return_fast done");
  endtask

  // interrupt return without restore, priority mode on
  task automatic t_irq_return_prio();
    bus_write(CRRO_OFS_PC, 32'h00000200);
    run_op(16'hD800, 1'b0);
    rd_chk("stack top", CRRO_OFS_STKTOP, 32'h00000202);
    bus_write(CRRO_OFS_WORK, 32'h00000055);
    bus_write(CRRO_OFS_FLAGS, 32'h00000066);
    bus_write(CRRO_OFS_IRQCFG, 32'h00000005);
    run_op(16'h0010, 1'b0);
    rd_chk("pc", CRRO_OFS_PC, 32'h00000202);
    rd_chk("irq cfg", CRRO_OFS_IRQCFG, 32'h00000007);
    rd_chk("work", CRRO_OFS_WORK, 32'h00000055);
    rd_chk("flags", CRRO_OFS_FLAGS, 32'h00000066);
    run_op(16'hD800, 1'b0);
    bus_write(CRRO_OFS_IRQCFG, 32'h00000004);
    run_op(16'h0010, 1'b0);
    rd_chk("irq cfg", CRRO_OFS_IRQCFG, 32'h00000005);
    rd_chk("pc", CRRO_OFS_PC, 32'h00000204);
    $display("test irq_return_prio done");
  endtask

  // unknown opcode only flags itself, flag clears by write one
  task automatic t_unknown();
    run_op(16'hFFFF, 1'b0);
    rd_chk("stat", CRRO_OFS_STAT, 32'h00000004);
    rd_chk("pc", CRRO_OFS_PC, 32'h00000204);
    bus_write(CRRO_OFS_STAT, 32'h00000004);
    rd_chk("stat", CRRO_OFS_STAT, 32'h00000000);
    $display("test unknown done");
  endtask

  // software reset clears state and pulses once
  task automatic t_soft_reset();
    int p0;
    bus_write(CRRO_OFS_PC, 32'h00000300);
    run_op(16'hD800, 1'b0);
    bus_write(CRRO_OFS_WORK, 32'h00000077);
    bus_write(CRRO_OFS_IRQCFG, 32'h00000007);
    p0 = pulses;
    run_op(CRRO_OP_SRST, 1'b0);
    check32("reset pulses", 32'h00000001, 32'(pulses - p0));
    rd_chk("pc", CRRO_OFS_PC, 32'h00000000);
    rd_chk("work", CRRO_OFS_WORK, 32'h00000000);
    rd_chk("latch", CRRO_OFS_LATCH, 32'h00000000);
    rd_chk("irq cfg", CRRO_OFS_IRQCFG, 32'h00000000);
    rd_chk("shadow", CRRO_OFS_SHADOW, 32'h00000000);
    rd_chk("stat", CRRO_OFS_STAT, 32'h00000000);
    $display("test soft_reset done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_after_reset();
    t_call();
    t_lit_return();
    t_irq_return_fast();
    t_irq_return_prio();
    t_unknown();
    t_soft_reset();
    give_verdict();
  end
endmodule
